//--- sim/mrpv_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module mrpv_ctrl_test import mrpv_pkg::*; ;
    logic clk_i;
    logic rst_n_i = 1'b0;
    logic crc_err_i = 1'b0;
    logic ck, cke, cs_n, termination_control_pin, par;
    mrpv_cmd_t pins;
    logic cmd_valid_o, nominal_termination_en_o, parked_termination_en_o, vref_mon_en_o;
    mrpv_cmd_t cmd_o;
    mrpv_mr5_t mr5_o;
    mrpv_mr6_t mr6_o;
    logic [3:0] ccd_clocks_o;
    int err_count = 0;
    int n_checks = 0;
    int n_exec = 0;
    int n_prev = 0;
    int n_ck = 0;
    int ck_exec = 0;
    int ck_req = 0;
    logic [3:0] ccd_exp [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h4};
    int lat_exp [5] = '{0, 4, 5, 6, 8};
    mrpv_mr6_t m6;
    mrpv_mr6_t m6_prev;

    mrpv_host_model host (.ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .odt_o(termination_control_pin), .par_o(par), .cmd_o(pins));

    mrpv_ctrl DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n),
        .act_n_i(pins.act_n), .ras_n_i(pins.ras_n), .cas_n_i(pins.cas_n), .we_n_i(pins.we_n),
        .bg_i(pins.bg), .ba_i(pins.ba), .a17_i(pins.a17), .addr_i(pins.addr), .par_i(par),
        .odt_i(termination_control_pin), .crc_err_i(crc_err_i), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o),
        .mr5_o(mr5_o), .mr6_o(mr6_o), .nominal_termination_en_o(nominal_termination_en_o), .parked_termination_en_o(parked_termination_en_o),
        .vref_mon_en_o(vref_mon_en_o), .ccd_clocks_o(ccd_clocks_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge ck) n_ck++;
    always @(posedge clk_i) if (cmd_valid_o === 1'b1) begin
        n_exec++;
        ck_exec = n_ck;
    end

    function automatic logic [13:0] op6(input mrpv_mr6_t m);
        return {1'b0, m.ccd, 2'b00, m.train_en, m.range_sel, m.level};
    endfunction : op6

    // Long settle covers the deepest parity latency plus the pin synchroniser
    task automatic mrs(input logic [2:0] sel, input logic [13:0] op, input logic bad);
        mrpv_cmd_t c;
        c = '0;
        c.act_n = 1'b1; // Strobes left low
        c.bg = {1'b0, sel[2]};
        c.ba = sel[1:0];
        c.addr = op; // Reserved bits come in as zero
        host.issue(c, bad);
        ck_req = n_ck;
        repeat (12) @(posedge ck); // Far above any column spacing
    endtask : mrs

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK(mr5_o, 10'h000)
        `CHK(mr6_o, 11'h000)
        `CHK(ccd_clocks_o, 4'h4)
        for (int i = 0; i < 6; i++) begin
            m6.ccd = i[2:0];
            m6.train_en = 1'b1;
            m6.range_sel = i[0];
            m6.level = 6'(i * 9);
            mrs(3'h6, op6(m6), 1'b0);
            if (i < 5) `CHK(mr6_o, m6)
            `CHK(ccd_clocks_o, ccd_exp[i])
            `CHK(vref_mon_en_o, 1'b1)
        end
        m6.ccd = 3'h4;
        m6.train_en = 1'b0;
        mrs(3'h6, op6(m6), 1'b0);
        `CHK(mr6_o, m6)
        `CHK(vref_mon_en_o, 1'b0)
        mrs(3'h7, 14'h0CFF, 1'b0);
        `CHK(mr6_o, m6)
        `CHK(mr5_o, 10'h000)
        m6.train_en = 1'b1;
        m6.level = 6'h01;
        mrs(3'h6, op6(m6), 1'b1);
        `CHK(mr6_o, m6)
        `CHK(mr5_o.par_err, 1'b0)
        host.odt_mode = 2'h3;
        for (int i = 0; i < 5; i++) begin
            mrs(3'h5, {11'h0, i[2:0]}, 1'b0);
            m6.level = 6'(i + 2);
            mrs(3'h6, op6(m6), 1'b0);
            `CHK(mr6_o, m6)
            `CHK(ck_exec - ck_req, lat_exp[i])
        end
        n_prev = n_exec;
        m6_prev = m6;
        m6.level = 6'h2A;
        mrs(3'h6, op6(m6), 1'b1);
        `CHK(mr6_o, m6_prev)
        `CHK(n_exec, n_prev)
        `CHK(mr5_o.par_err, 1'b1)
        mrs(3'h6, op6(m6), 1'b1);
        `CHK(mr6_o, m6)
        mrs(3'h5, 14'h0204, 1'b0);
        `CHK(mr5_o, 10'h204)
        n_prev = n_exec;
        m6_prev = m6;
        m6.level = 6'h15;
        mrs(3'h6, op6(m6), 1'b1);
        mrs(3'h6, op6(m6), 1'b1);
        `CHK(mr6_o, m6_prev)
        `CHK(n_exec, n_prev)
        mrs(3'h5, 14'h0000, 1'b0);
        `CHK(mr5_o, 10'h000)
        @(posedge clk_i) crc_err_i <= 1'b1;
        @(posedge clk_i) crc_err_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(mr5_o.crc_err, 1'b1)
        mrs(3'h5, 14'h0068, 1'b0);
        `CHK(mr5_o, 10'h068)
        host.odt_mode = 2'h2;
        host.pd = 1'b1;
        repeat (4) @(posedge ck);
        `CHK(nominal_termination_en_o, 1'b0)
        `CHK(parked_termination_en_o, 1'b1)
        host.pd = 1'b0;
        host.odt_mode = 2'h0;
        repeat (4) @(posedge ck);
        mrs(3'h5, 14'h0000, 1'b0);
        `CHK(mr5_o.crc_err, 1'b0)
        conclude();
    end

    // About 30 commands of 13 link periods each, with ample margin
    initial begin
        #100us;
        err_count++;
        conclude();
    end
endmodule : mrpv_ctrl_test

//--- sim/mrpv_host_model.sv
`timescale 1ns/1ps
module mrpv_host_model import mrpv_pkg::*; (
    output logic ck_o,
    output logic cke_o,
    output logic cs_n_o,
    output logic odt_o,
    output logic par_o,
    output mrpv_cmd_t cmd_o
);
    logic pd = 1'b0;
    logic [1:0] odt_mode = 2'h0;

    initial begin
        ck_o = 1'b0;
        forever #40 ck_o = ~ck_o;
    end

    initial begin
        cs_n_o = 1'b1;
        par_o = 1'b0;
        cmd_o = '0;
    end

    // Floating pin in power-down shown as a toggling level, never a stale one
    always @(negedge ck_o) begin
        cke_o <= ~pd;
        odt_o <= (pd && odt_mode == 2'h2) ? ~odt_o : odt_mode[0];
    end

    // Pins change on the falling edge, so they stand across the sampling rise
    task automatic issue(input mrpv_cmd_t c, input logic bad);
        @(negedge ck_o);
        cs_n_o <= 1'b0;
        cmd_o <= c;
        par_o <= (^c) ^ bad;
        @(negedge ck_o);
        cs_n_o <= 1'b1;
        cmd_o <= ~c;
        par_o <= ~((^c) ^ bad);
    endtask : issue
endmodule : mrpv_host_model

//--- src/mrpv_ctrl.sv
`timescale 1ns/1ps
`include "mrpv_regs.svh"
module mrpv_ctrl import mrpv_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ck_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic act_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [1:0] bg_i,
    input wire logic [1:0] ba_i,
    input wire logic a17_i,
    input wire logic [13:0] addr_i,
    input wire logic par_i,
    input wire logic odt_i,
    input wire logic crc_err_i,
    output logic cmd_valid_o,
    output mrpv_cmd_t cmd_o,
    output mrpv_mr5_t mr5_o,
    output mrpv_mr6_t mr6_o,
    output logic nominal_termination_en_o,
    output logic parked_termination_en_o,
    output logic vref_mon_en_o,
    output logic [3:0] ccd_clocks_o
);

    function automatic logic [3:0] lat_clocks(input logic [2:0] code);
        unique case (code)
            `MRPV_LAT_C4: lat_clocks = `MRPV_LAT_N4;
            `MRPV_LAT_C5: lat_clocks = `MRPV_LAT_N5;
            `MRPV_LAT_C6: lat_clocks = `MRPV_LAT_N6;
            `MRPV_LAT_C8: lat_clocks = `MRPV_LAT_N8;
            default: lat_clocks = 4'h0;
        endcase
    endfunction : lat_clocks

    function automatic logic [3:0] ccd_clocks(input logic [2:0] code);
        // Reserved codes fall back to the shortest spacing
        if (code <= `MRPV_CCD_MAX_CODE) begin
            ccd_clocks = `MRPV_CCD_MIN + {1'b0, code};
        end else begin
            ccd_clocks = `MRPV_CCD_MIN;
        end
    endfunction : ccd_clocks

    mrpv_pins_t pins_raw;
    mrpv_pins_t sync1_q;
    mrpv_pins_t sync2_q;
    logic ck_prev_q;
    logic ck_rise;
    mrpv_slot_t pipe_q [`MRPV_PIPE_DEPTH];
    mrpv_mr5_t mr5_q;
    mrpv_mr6_t mr6_q;
    logic pd_q;
    logic new_sel;
    logic new_err;
    logic new_chk;
    logic [3:0] lat_n;
    mrpv_slot_t exe;
    logic exe_ok;
    logic exe_mrs;
    logic [21:0] mr_bits;
    logic [2:0] mr_sel;
    logic mr5_wr;
    logic mr6_wr;
    logic par_set;

    assign pins_raw = '{ck: ck_i, cke: cke_i, cs_n: cs_n_i, termination_control_pin: odt_i, par: par_i,
                        cmd: '{act_n: act_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i,
                               bg: bg_i, ba: ba_i, a17: a17_i, addr: addr_i}};

    // Pins come from the link clock domain and pass two synchroniser stages
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            ck_prev_q <= 1'b0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            ck_prev_q <= sync2_q.ck;
        end
    end

    assign ck_rise = sync2_q.ck & ~ck_prev_q;
    assign lat_n = lat_clocks(mr5_q.par_lat);

    always_comb begin
        new_sel = ck_rise & ~sync2_q.cs_n & sync2_q.cke;
        // Excludes clock enable, termination and select pins
        new_err = ^{sync2_q.cmd, sync2_q.par};
        // Non-persistent mode skips the check while the flag is up
        new_chk = ~mr5_q.par_err | mr5_q.persist;
        if (lat_n == 4'h0) begin
            // No latency programmed: execute at once, unchecked
            exe = '{vld: new_sel, chk: 1'b0, err: new_err, cmd: sync2_q.cmd};
        end else begin
            exe = pipe_q[3'(lat_n - 4'h1)];
            exe.vld = exe.vld & ck_rise;
        end
        exe_ok = exe.vld & ~(exe.chk & exe.err);
        par_set = exe.vld & exe.chk & exe.err;
    end

    // Each command waits the programmed latency before it may execute
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `MRPV_PIPE_DEPTH; i++) begin
                pipe_q[i] <= '0;
            end
        end else if (ck_rise) begin
            if (mr5_wr) begin
                // Drops commands behind a fifth-register write; a new latency would replay the one leaving
                for (int i = 0; i < `MRPV_PIPE_DEPTH; i++) begin
                    pipe_q[i] <= '0;
                end
            end else begin
                pipe_q[0] <= '{vld: new_sel & (lat_n != 4'h0), chk: new_chk, err: new_err,
                               cmd: sync2_q.cmd};
                for (int i = 1; i < `MRPV_PIPE_DEPTH; i++) begin
                    pipe_q[i] <= pipe_q[i-1];
                end
            end
        end
    end

    always_comb begin
        mr_bits = {exe.cmd.bg, exe.cmd.ba, exe.cmd.a17, exe.cmd.ras_n, exe.cmd.cas_n, exe.cmd.we_n,
                   exe.cmd.addr};
        mr_sel = mr_bits[`MRPV_SEL_HI:`MRPV_SEL_LO];
        exe_mrs = exe_ok & exe.cmd.act_n & ~exe.cmd.ras_n
                  & ~exe.cmd.cas_n & ~exe.cmd.we_n;
        mr5_wr = exe_mrs & (mr_sel == `MRPV_SEL_MR5);
        mr6_wr = exe_mrs & (mr_sel == `MRPV_SEL_MR6);
    end

    // Failing commands never reach the core
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o <= '0;
        end else begin
            cmd_valid_o <= exe_ok;
            if (exe_ok) begin
                cmd_o <= exe.cmd;
            end
        end
    end

    // Reserved bits 21, 17, 13, 12, 11, 10 are not stored
    // One process owns the whole register, flags included
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mr5_q <= `MRPV_MR5_RESET; // Parity checking off
        end else begin
            if (mr5_wr) begin
                mr5_q.persist <= mr_bits[`MRPV_MR5_PERSIST];
                mr5_q.park <= mr_bits[`MRPV_MR5_PARK_HI:`MRPV_MR5_PARK_LO];
                mr5_q.buf_off <= mr_bits[`MRPV_MR5_BUF_OFF];
                mr5_q.par_lat <= mr_bits[`MRPV_MR5_LAT_HI:`MRPV_MR5_LAT_LO];
            end
            // Sticky flags: a new error wins over a clearing write
            mr5_q.par_err <= par_set | (mr5_q.par_err & ~(mr5_wr & ~mr_bits[`MRPV_MR5_PAR_ERR]));
            mr5_q.crc_err <= crc_err_i | (mr5_q.crc_err & ~(mr5_wr & ~mr_bits[`MRPV_MR5_CRC_ERR]));
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mr6_q <= `MRPV_MR6_RESET;
        end else if (mr6_wr) begin
            mr6_q.ccd <= mr_bits[`MRPV_MR6_CCD_HI:`MRPV_MR6_CCD_LO];
            mr6_q.train_en <= mr_bits[`MRPV_MR6_TRAIN];
            mr6_q.range_sel <= mr_bits[`MRPV_MR6_RANGE];
            mr6_q.level <= mr_bits[`MRPV_MR6_VAL_HI:`MRPV_MR6_VAL_LO];
        end
    end

    // Power-down follows clock enable, sampled on link clock edges
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pd_q <= 1'b0;
        end else if (ck_rise) begin
            pd_q <= ~sync2_q.cke;
        end
    end

    // In power-down with the buffer off the pin may float, so it is ignored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nominal_termination_en_o <= 1'b0;
            parked_termination_en_o <= 1'b0;
        end else begin
            nominal_termination_en_o <= sync2_q.termination_control_pin & ~(pd_q & mr5_q.buf_off);
            parked_termination_en_o <= (mr5_q.park != 3'h0) & ~(sync2_q.termination_control_pin & ~(pd_q & mr5_q.buf_off));
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mr5_o <= '0;
            mr6_o <= '0;
            vref_mon_en_o <= 1'b0;
            ccd_clocks_o <= `MRPV_CCD_MIN;
        end else begin
            mr5_o <= mr5_q;
            mr6_o <= mr6_q;
            vref_mon_en_o <= mr6_q.train_en;
            ccd_clocks_o <= ccd_clocks(mr6_q.ccd);
        end
    end

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_par_flag_hold: assert property (mr5_q.par_err && !mr5_wr |=> mr5_q.par_err)
        else $error("parity flag dropped without clear");
    a_par_flag_set: assert property (par_set |=> mr5_q.par_err)
        else $error("parity error not flagged");
    a_crc_flag_set: assert property (crc_err_i |=> mr5_q.crc_err ##1 mr5_o.crc_err)
        else $error("write-check error not flagged");
    a_lat_off_nocheck: assert property (mr5_q.par_lat == `MRPV_LAT_OFF |-> !par_set)
        else $error("parity checked with latency off");
    a_reset_parity_off: assert property ($rose(rst_n_i) |-> mr5_q.par_lat == `MRPV_LAT_OFF)
        else $error("parity enabled after reset");
    a_bad_cmd_dropped: assert property (par_set |=> !cmd_valid_o)
        else $error("command with parity error executed");
    a_persist_skip: assert property (new_sel && mr5_q.par_err && !mr5_q.persist |-> !new_chk)
        else $error("checking continued with flag set");
    a_dnu_ignored: assert property (exe_mrs && mr_sel == `MRPV_SEL_DNU |=> $stable(mr6_q)
        && $stable({mr5_q.persist, mr5_q.park, mr5_q.buf_off, mr5_q.par_err, mr5_q.par_lat}))
        else $error("reserved select changed a register");
    a_train_write: assert property (mr6_wr |=> mr6_q.train_en == $past(mr_bits[`MRPV_MR6_TRAIN])
        ##1 vref_mon_en_o == mr6_q.train_en)
        else $error("training enable not written");
    a_ccd_decode: assert property (mr6_q.ccd == 3'h4 |=> ccd_clocks_o == 4'h8)
        else $error("column spacing decode wrong");
    a_float_no_nom: assert property (pd_q && mr5_q.buf_off |=> !nominal_termination_en_o)
        else $error("nominal termination with buffer off");

    // State and outputs are checked one clock after their cause, the strobes in the same cycle
    a_par_flag_clear: assert property (mr5_wr && !mr_bits[`MRPV_MR5_PAR_ERR] |=> !mr5_q.par_err)
        else $error("parity flag not cleared");
    a_crc_flag_hold: assert property (mr5_q.crc_err && !mr5_wr |=> mr5_q.crc_err)
        else $error("write-check flag dropped without clear");
    a_crc_set_wins: assert property (crc_err_i && mr5_wr |=> mr5_q.crc_err)
        else $error("clearing write beat a new write-check error");
    a_lat_write: assert property (mr5_wr |=>
        mr5_q.par_lat == $past(mr_bits[`MRPV_MR5_LAT_HI:`MRPV_MR5_LAT_LO]))
        else $error("parity latency not written");
    a_ccd_write: assert property (mr6_wr |=>
        mr6_q.ccd == $past(mr_bits[`MRPV_MR6_CCD_HI:`MRPV_MR6_CCD_LO]))
        else $error("column spacing code not written");
    a_range_write: assert property (mr6_wr |=> mr6_q.range_sel == $past(mr_bits[`MRPV_MR6_RANGE]))
        else $error("reference range not written");
    a_level_write: assert property (mr6_wr |=>
        mr6_q.level == $past(mr_bits[`MRPV_MR6_VAL_HI:`MRPV_MR6_VAL_LO]))
        else $error("reference level not written");
    a_ccd_reserved: assert property (mr6_q.ccd > `MRPV_CCD_MAX_CODE |=> ccd_clocks_o == `MRPV_CCD_MIN)
        else $error("reserved spacing code not at minimum");
    a_park_kept: assert property (pd_q && mr5_q.buf_off && mr5_q.park != 3'h0 |=> parked_termination_en_o)
        else $error("parked termination lost with buffer off");
    a_pd_entry: assert property (ck_rise && !sync2_q.cke |=> pd_q)
        else $error("power-down not entered");
    a_cmd_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
        else $error("command executed twice");
    a_mrs_strobes: assert property (mr6_wr |-> exe.cmd.act_n && !exe.cmd.ras_n && !exe.cmd.cas_n && !exe.cmd.we_n)
        else $error("register written without strobes low");

    c_parity_error: cover property (par_set ##[1:50] mr5_wr);
    c_mr6_write: cover property (mr6_wr ##1 mr6_q.train_en);
    c_checked_exec: cover property (exe_ok && exe.chk);
    c_powerdown_float: cover property (pd_q && mr5_q.buf_off && sync2_q.termination_control_pin);
    c_persist_block: cover property (par_set && mr5_q.persist);

endmodule : mrpv_ctrl

//--- src/mrpv_pkg.sv
package mrpv_pkg;

    typedef struct packed {
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bg;
        logic [1:0] ba;
        logic a17;
        logic [13:0] addr;
    } mrpv_cmd_t;

    typedef struct packed {
        logic ck;
        logic cke;
        logic cs_n;
        logic termination_control_pin;
        logic par;
        mrpv_cmd_t cmd;
    } mrpv_pins_t;

    typedef struct packed {
        logic vld;
        logic chk;
        logic err;
        mrpv_cmd_t cmd;
    } mrpv_slot_t;

    typedef struct packed {
        logic persist;
        logic [2:0] park;
        logic buf_off;
        logic par_err;
        logic crc_err;
        logic [2:0] par_lat;
    } mrpv_mr5_t;

    typedef struct packed {
        logic [2:0] ccd;
        logic train_en;
        logic range_sel;
        logic [5:0] level;
    } mrpv_mr6_t;

endpackage : mrpv_pkg

//--- src/mrpv_regs.svh
`ifndef MRPV_REGS_SVH
`define MRPV_REGS_SVH

// Mode-register select codes on bank-group/bank bits 20:18
`define MRPV_SEL_MR5 3'h5
`define MRPV_SEL_MR6 3'h6
`define MRPV_SEL_DNU 3'h7
`define MRPV_SEL_HI 20
`define MRPV_SEL_LO 18

// Fifth mode register field positions
`define MRPV_MR5_PERSIST 9
`define MRPV_MR5_PARK_HI 8
`define MRPV_MR5_PARK_LO 6
`define MRPV_MR5_BUF_OFF 5
`define MRPV_MR5_PAR_ERR 4
`define MRPV_MR5_CRC_ERR 3
`define MRPV_MR5_LAT_HI 2
`define MRPV_MR5_LAT_LO 0

// Column delay / reference training register field positions
`define MRPV_MR6_CCD_HI 12
`define MRPV_MR6_CCD_LO 10
`define MRPV_MR6_TRAIN 7
`define MRPV_MR6_RANGE 6
`define MRPV_MR6_VAL_HI 5
`define MRPV_MR6_VAL_LO 0

// Reset values
`define MRPV_MR5_RESET 10'h000
`define MRPV_MR6_RESET 11'h000

// Parity latency codes and clock counts
`define MRPV_LAT_OFF 3'h0
`define MRPV_LAT_C4 3'h1
`define MRPV_LAT_C5 3'h2
`define MRPV_LAT_C6 3'h3
`define MRPV_LAT_C8 3'h4
`define MRPV_LAT_N4 4'h4
`define MRPV_LAT_N5 4'h5
`define MRPV_LAT_N6 4'h6
`define MRPV_LAT_N8 4'h8

// Same-group column spacing
`define MRPV_CCD_MIN 4'h4
`define MRPV_CCD_MAX_CODE 3'h4

// Parity pipeline depth (largest latency)
`define MRPV_PIPE_DEPTH 8

`endif
